// *** logic/mcuie_core.sv ***
// Instruction decode and execute core with Wishbone access to its state
// Functional notes
// RULE1: Immediate-to-memory move writes only system registers 0x80..0x87, one cycle.
// RULE2: Bank-zero forms always address data memory bank 0.
// RULE3: Exchange swaps accumulator and operand, flags untouched, one cycle plus N.
// RULE4: Table read loads ROM word at pointer pair: low to accumulator, high to multiply-high.
// RULE5: Add forms set carry on carry out, and update digit carry and zero.
// RULE6: Subtract forms clear carry on borrow; with-borrow form also subtracts inverted carry.
// RULE7: Multiply gives 16-bit product, low in accumulator, high in multiply-high, two cycles.
// RULE8: AND, OR, XOR keep carry and digit carry unchanged.
// RULE9: Nibble swap exchanges operand halves into accumulator or back to memory.
// RULE10: Rotates pass through carry, to accumulator or memory at one plus N.
// RULE11: Bit set and clear write only the chosen bit, one plus N cycles.
// RULE12: Compare sets zero and carry from accumulator minus operand, skips when equal.
// RULE13: Increment/decrement skip on zero result; memory forms cost one plus N plus S.
// RULE14: Bit test skips when tested bit equals the value the opcode names.
// RULE15: Jump loads page bits into counter bits 15..14, address field below, two cycles.
// RULE16: Call pushes the counter then jumps; return pops it; both two cycles.
// RULE17: Return from interrupt pops the counter and re-enables global interrupts.
// RULE18: Push and pop save accumulator and flags except timeout and power-down bits.
// RULE19: Operand in general RAM adds one cycle; system register adds none. The core adds it only on forms that write memory.
// RULE20: Skip forms take one more cycle when the condition holds.
// RULE21: Flags an instruction leaves unaffected keep their values.
//
// Added by the designer: the Wishbone interface to the registers and the placing of the registers.
module mcuie_core (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Wishbone slave
  input wire mcuie_pkg::mcuie_wb_req_t wb_req,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Program memory port
  output logic [15:0] rom_addr,
  output logic rom_rd,
  input wire logic [15:0] rom_data,
  // Core status
  output logic busy,
  output logic gie
);
  import mcuie_pkg::*;

  mcuie_state_t state;
  mcuie_instr_t instr;
  logic [7:0] acc;
  logic [15:0] pc;
  logic [7:0] sysr [0:SYS_REGS-1];
  logic [7:0] ram [0:RAM_SIZE-1];
  logic [15:0] stack [0:STACK_DEPTH-1];
  logic [2:0] sp;
  logic [7:0] shadow_acc;
  logic [5:0] shadow_flags;
  logic [8:0] mem_addr;
  logic last_skip;
  logic [1:0] last_cycles;
  logic [1:0] cnt;
  logic wb_hit;
  logic bus_wr;
  logic idle;
  logic exec;
  logic bank_zero;
  logic [8:0] eff;
  logic [7:0] m;
  logic is_ram;
  logic [7:0] flags;
  logic [9:0] ar;
  logic use_ar;
  logic ar_to_mem;
  logic [7:0] next_acc;
  logic acc_we;
  logic [7:0] res;
  logic mem_we;
  logic mulhi_we;
  logic pop_flags;
  logic next_c;
  logic next_digit;
  logic next_z;
  logic skip;
  logic ram_extra;
  logic long_op;
  logic [1:0] cycles;
  logic [15:0] product;
  logic [7:0] inc_v;
  logic [7:0] dec_v;
  logic [31:0] rd_mux;

  // Operand read: system window, zero above it, RAM below
  function automatic logic [7:0] fetch(input logic [8:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a[7]) begin
      if (a[7:0] <= SYS_LAST) begin
        v = sysr[a[2:0]];
      end
    end else begin
      v = ram[{a[8], a[6:0]}];
    end
    return v;
  endfunction

  // Returns {digit carry, carry, sum}
  function automatic logic [9:0] addsub(input logic [7:0] a, input logic [7:0] b, input logic cin);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    return {h[4], s};
  endfunction

  assign wb_hit = wb_req.cyc & wb_req.stb;
  assign bus_wr = wb_hit & wb_req.we & wb_ack_o & ce;
  assign idle = (state == ST_IDLE);
  assign exec = (state == ST_EXEC) & ce;
  assign flags = sysr[SYS_FLAGS];
  assign is_ram = ~instr.addr[7];
  assign product = {8'h00, acc} * {8'h00, m};
  assign inc_v = m + 8'h01;
  assign dec_v = m - 8'h01;

  // RULE2: bank zero forms
  assign bank_zero = instr.op inside {OP_BZ_MOV_A_M, OP_BZ_MOV_M_A, OP_BZ_MOV_M_I, OP_BZ_XCH, OP_BZ_ADD_M_A,
                                      OP_BZ_BCLR, OP_BZ_BSET, OP_BZ_BIT_SKIP_CLR, OP_BZ_BIT_SKIP_SET};
  assign eff = {bank_zero ? 1'b0 : sysr[SYS_BANK][0], instr.addr};
  // Process form so that storage writes re-evaluate the operand, not only address changes
  always_comb begin
    m = fetch(eff);
  end

  // Decode and execute of the held instruction
  always_comb begin
    ar = 10'h000;
    use_ar = 1'b0;
    ar_to_mem = 1'b0;
    next_acc = acc;
    acc_we = 1'b0;
    res = m;
    mem_we = 1'b0;
    mulhi_we = 1'b0;
    pop_flags = 1'b0;
    // RULE21: unaffected flags hold
    next_c = flags[FLAG_C];
    next_digit = flags[FLAG_DIGIT];
    next_z = flags[FLAG_Z];
    skip = 1'b0;
    ram_extra = 1'b0;
    long_op = 1'b0;
    case (instr.op)
      OP_MOV_A_M, OP_BZ_MOV_A_M: begin
        next_acc = m;
        acc_we = 1'b1;
        next_z = (m == 8'h00);
      end
      OP_MOV_M_A, OP_BZ_MOV_M_A: begin
        res = acc;
        mem_we = 1'b1;
      end
      OP_MOV_A_I: begin
        next_acc = instr.imm;
        acc_we = 1'b1;
      end
      // RULE1: system window only
      OP_BZ_MOV_M_I: begin
        res = instr.imm;
        mem_we = instr.addr[7] & (instr.addr <= SYS_LAST);
      end
      // RULE3: swap, no flags
      OP_XCH, OP_BZ_XCH: begin
        next_acc = m;
        acc_we = 1'b1;
        res = acc;
        mem_we = 1'b1;
        ram_extra = 1'b1;
      end
      OP_ROM_READ: long_op = 1'b1;
      // RULE5: add forms
      OP_ADDC_A_M: begin ar = addsub(acc, m, flags[FLAG_C]); use_ar = 1'b1; end
      OP_ADDC_M_A: begin ar = addsub(acc, m, flags[FLAG_C]); use_ar = 1'b1; ar_to_mem = 1'b1; end
      OP_ADD_A_M: begin ar = addsub(acc, m, 1'b0); use_ar = 1'b1; end
      OP_ADD_M_A, OP_BZ_ADD_M_A: begin ar = addsub(acc, m, 1'b0); use_ar = 1'b1; ar_to_mem = 1'b1; end
      OP_ADD_A_I: begin ar = addsub(acc, instr.imm, 1'b0); use_ar = 1'b1; end
      // RULE6: carry is the inverted borrow
      OP_SUBB_A_M: begin ar = addsub(acc, ~m, flags[FLAG_C]); use_ar = 1'b1; end
      OP_SUBB_M_A: begin ar = addsub(acc, ~m, flags[FLAG_C]); use_ar = 1'b1; ar_to_mem = 1'b1; end
      OP_SUB_A_M: begin ar = addsub(acc, ~m, 1'b1); use_ar = 1'b1; end
      OP_SUB_M_A: begin ar = addsub(acc, ~m, 1'b1); use_ar = 1'b1; ar_to_mem = 1'b1; end
      OP_SUB_A_I: begin ar = addsub(acc, ~instr.imm, 1'b1); use_ar = 1'b1; end
      // RULE7: product split
      OP_MUL: begin
        next_acc = product[7:0];
        acc_we = 1'b1;
        mulhi_we = 1'b1;
        next_z = (product[7:0] == 8'h00);
        long_op = 1'b1;
      end
      // RULE8: logic keeps carry and digit carry
      OP_AND_A_M, OP_AND_A_I, OP_OR_A_M, OP_OR_A_I, OP_XOR_A_M, OP_XOR_A_I,
      OP_AND_M_A, OP_OR_M_A, OP_XOR_M_A: begin
        case (instr.op)
          OP_AND_A_M, OP_AND_M_A: res = acc & m;
          OP_AND_A_I: res = acc & instr.imm;
          OP_OR_A_M, OP_OR_M_A: res = acc | m;
          OP_OR_A_I: res = acc | instr.imm;
          OP_XOR_A_I: res = acc ^ instr.imm;
          default: res = acc ^ m;
        endcase
        next_z = (res == 8'h00);
        if (instr.op inside {OP_AND_M_A, OP_OR_M_A, OP_XOR_M_A}) begin
          mem_we = 1'b1;
          ram_extra = 1'b1;
        end else begin
          next_acc = res;
          acc_we = 1'b1;
        end
      end
      // RULE9: nibble swap
      OP_SWAP_A: begin next_acc = {m[3:0], m[7:4]}; acc_we = 1'b1; end
      OP_SWAP_M: begin res = {m[3:0], m[7:4]}; mem_we = 1'b1; ram_extra = 1'b1; end
      // RULE10: rotate through carry
      OP_RRC_A: begin next_acc = {flags[FLAG_C], m[7:1]}; acc_we = 1'b1; next_c = m[0]; end
      OP_RRC_M: begin res = {flags[FLAG_C], m[7:1]}; mem_we = 1'b1; ram_extra = 1'b1; next_c = m[0]; end
      OP_RLC_A: begin next_acc = {m[6:0], flags[FLAG_C]}; acc_we = 1'b1; next_c = m[7]; end
      OP_RLC_M: begin res = {m[6:0], flags[FLAG_C]}; mem_we = 1'b1; ram_extra = 1'b1; next_c = m[7]; end
      OP_CLR: begin res = 8'h00; mem_we = 1'b1; end
      // RULE11: single bit write
      OP_BCLR, OP_BZ_BCLR: begin res = m & ~(8'h01 << instr.bit_sel); mem_we = 1'b1; ram_extra = 1'b1; end
      OP_BSET, OP_BZ_BSET: begin res = m | (8'h01 << instr.bit_sel); mem_we = 1'b1; ram_extra = 1'b1; end
      // RULE12: compare and skip on equal
      OP_CMP_SKIP_I, OP_CMP_SKIP_M: begin
        ar = addsub(acc, (instr.op == OP_CMP_SKIP_I) ? ~instr.imm : ~m, 1'b1);
        next_c = ar[8];
        next_z = (ar[7:0] == 8'h00);
        skip = (ar[7:0] == 8'h00);
      end
      // RULE13: skip on zero result
      OP_INC_SKIP_A: begin next_acc = inc_v; acc_we = 1'b1; skip = (inc_v == 8'h00); end
      OP_INC_SKIP_M: begin res = inc_v; mem_we = 1'b1; ram_extra = 1'b1; skip = (inc_v == 8'h00); end
      OP_DEC_SKIP_A: begin next_acc = dec_v; acc_we = 1'b1; skip = (dec_v == 8'h00); end
      OP_DEC_SKIP_M: begin res = dec_v; mem_we = 1'b1; ram_extra = 1'b1; skip = (dec_v == 8'h00); end
      // RULE14: bit test skip
      OP_BIT_SKIP_CLR, OP_BZ_BIT_SKIP_CLR: skip = ~m[instr.bit_sel];
      OP_BIT_SKIP_SET, OP_BZ_BIT_SKIP_SET: skip = m[instr.bit_sel];
      OP_JMP, OP_CALL, OP_RET, OP_RETI: long_op = 1'b1;
      // RULE18: pop restores accumulator
      OP_POP: begin next_acc = shadow_acc; acc_we = 1'b1; pop_flags = 1'b1; end
      default: begin
      end
    endcase
    if (use_ar) begin
      next_c = ar[8];
      next_digit = ar[9];
      next_z = (ar[7:0] == 8'h00);
      res = ar[7:0];
      if (ar_to_mem) begin
        mem_we = 1'b1;
        ram_extra = 1'b1;
      end else begin
        next_acc = ar[7:0];
        acc_we = 1'b1;
      end
    end
  end

  // RULE19: RAM operand costs one more on forms that read and write memory; RULE20: taken skip one more
  assign cycles = CYC_ONE + {1'b0, long_op} + {1'b0, ram_extra & is_ram} + {1'b0, skip};

  // Wishbone answer: ack one cycle after request, dropped the cycle after
  always_ff @(posedge clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else if (ce) begin
      wb_ack_o <= wb_hit & ~wb_ack_o;
      if (wb_hit & ~wb_ack_o) begin
        wb_dat_o <= rd_mux;
      end
    end
  end

  always_comb begin
    rd_mux = 32'h00000000;
    if (wb_req.adr == ADR_INSTR) begin
      rd_mux = {7'h00, instr};
    end else if (wb_req.adr == ADR_STATUS) begin
      rd_mux = {27'h0000000, gie, last_cycles, last_skip, busy};
    end else if (wb_req.adr == ADR_ACC) begin
      rd_mux = {24'h000000, acc};
    end else if (wb_req.adr == ADR_PC) begin
      rd_mux = {16'h0000, pc};
    end else if (wb_req.adr == ADR_MEM_ADDR) begin
      rd_mux = {23'h000000, mem_addr};
    end else if (wb_req.adr == ADR_MEM_DATA) begin
      rd_mux = {24'h000000, fetch(mem_addr)};
    end else if (wb_req.adr == ADR_CTRL) begin
      rd_mux = {31'h00000000, gie};
    end
  end

  // Sequencer: issue, execute, ROM fetch, extra cycles
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ST_IDLE;
      instr <= '0;
      busy <= 1'b0;
      cnt <= 2'h0;
      last_cycles <= 2'h0;
      last_skip <= 1'b0;
    end else if (ce) begin
      case (state)
        ST_IDLE: begin
          if (bus_wr && wb_req.adr == ADR_INSTR && wb_req.sel == 4'hF) begin
            instr <= mcuie_instr_t'(wb_req.dat[24:0]);
            state <= ST_EXEC;
            busy <= 1'b1;
          end
        end
        ST_EXEC: begin
          last_cycles <= cycles;
          last_skip <= skip;
          cnt <= cycles - CYC_ONE;
          if (instr.op == OP_ROM_READ) begin
            state <= ST_ROM;
          end else if (cycles > CYC_ONE) begin
            state <= ST_WAIT;
          end else begin
            state <= ST_IDLE;
            busy <= 1'b0;
          end
        end
        ST_WAIT: begin
          cnt <= cnt - CYC_ONE;
          if (cnt == CYC_ONE) begin
            state <= ST_IDLE;
            busy <= 1'b0;
          end
        end
        default: begin
          state <= ST_IDLE;
          busy <= 1'b0;
        end
      endcase
    end
  end

  // RULE4: ROM word at pointer pair
  always_ff @(posedge clk) begin
    if (rst) begin
      rom_addr <= RST_PC;
      rom_rd <= 1'b0;
    end else if (ce) begin
      rom_rd <= exec && instr.op == OP_ROM_READ;
      if (exec && instr.op == OP_ROM_READ) begin
        rom_addr <= {sysr[SYS_PTR_HI], sysr[SYS_PTR_LO]};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      acc <= RST_BYTE;
    end else if (ce) begin
      if (state == ST_ROM) begin
        acc <= rom_data[7:0];
      end else if (exec && acc_we) begin
        acc <= next_acc;
      end else if (idle && bus_wr && wb_req.adr == ADR_ACC && wb_req.sel[0]) begin
        acc <= wb_req.dat[7:0];
      end
    end
  end

  // System registers; an explicit memory write to the flags wins over flag results
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < SYS_REGS; i++) begin
        sysr[i] <= RST_BYTE;
      end
    end else if (ce) begin
      if (state == ST_ROM) begin
        sysr[SYS_MULHI] <= rom_data[15:8];
      end
      if (exec) begin
        sysr[SYS_FLAGS][FLAG_C] <= next_c;
        sysr[SYS_FLAGS][FLAG_DIGIT] <= next_digit;
        sysr[SYS_FLAGS][FLAG_Z] <= next_z;
        // RULE18: status bits 7..6 are not restored
        if (pop_flags) begin
          sysr[SYS_FLAGS][5:0] <= shadow_flags;
        end
        if (mulhi_we) begin
          sysr[SYS_MULHI] <= product[15:8];
        end
        if (mem_we && eff[7] && eff[7:0] <= SYS_LAST) begin
          sysr[eff[2:0]] <= res;
        end
      end else if (idle && bus_wr && wb_req.adr == ADR_MEM_DATA && wb_req.sel[0]) begin
        if (mem_addr[7] && mem_addr[7:0] <= SYS_LAST) begin
          sysr[mem_addr[2:0]] <= wb_req.dat[7:0];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < RAM_SIZE; i++) begin
        ram[i] <= RST_BYTE;
      end
    end else if (ce) begin
      if (exec && mem_we && !eff[7]) begin
        ram[{eff[8], eff[6:0]}] <= res;
      end else if (idle && bus_wr && wb_req.adr == ADR_MEM_DATA && wb_req.sel[0] && !mem_addr[7]) begin
        ram[{mem_addr[8], mem_addr[6:0]}] <= wb_req.dat[7:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mem_addr <= 9'h000;
    end else if (ce && bus_wr && wb_req.adr == ADR_MEM_ADDR && wb_req.sel[1:0] == 2'h3) begin
      mem_addr <= wb_req.dat[8:0];
    end
  end

  // RULE15: page bits over address field; RULE16: call and return
  always_ff @(posedge clk) begin
    if (rst) begin
      pc <= RST_PC;
      sp <= 3'h0;
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stack[i] <= RST_PC;
      end
    end else if (exec) begin
      case (instr.op)
        OP_JMP: pc <= {sysr[SYS_PAGE][1:0], instr.addr[5:0], instr.imm};
        OP_CALL: begin
          stack[sp] <= pc + 16'h0001;
          sp <= sp + 3'h1;
          pc <= {sysr[SYS_PAGE][1:0], instr.addr[5:0], instr.imm};
        end
        OP_RET, OP_RETI: begin
          sp <= sp - 3'h1;
          pc <= stack[sp - 3'h1];
        end
        default: pc <= pc + 16'h0001 + {15'h0000, skip};
      endcase
    end
  end

  // RULE17: return from interrupt re-enables, and wins over a software clear
  always_ff @(posedge clk) begin
    if (rst) begin
      gie <= 1'b0;
    end else if (exec && instr.op == OP_RETI) begin
      gie <= 1'b1;
    end else if (bus_wr && wb_req.adr == ADR_CTRL && wb_req.sel[0]) begin
      gie <= wb_req.dat[CTRL_GIE_BIT];
    end
  end

  // RULE18: push saves accumulator and low flag bits
  always_ff @(posedge clk) begin
    if (rst) begin
      shadow_acc <= RST_BYTE;
      shadow_flags <= 6'h00;
    end else if (exec && instr.op == OP_PUSH) begin
      shadow_acc <= acc;
      shadow_flags <= flags[5:0];
    end
  end

  AST_IMM_WINDOW: assert property (@(posedge clk) disable iff (rst) // RULE1
    exec && instr.op == OP_BZ_MOV_M_I && mem_we |-> eff[7:0] >= 8'h80 && eff[7:0] <= 8'h87 && cycles == 2'h1)
    else $error("immediate move outside system window");
  AST_BANK_ZERO: assert property (@(posedge clk) disable iff (rst) // RULE2
    exec && bank_zero |-> eff[8] == 1'b0)
    else $error("bank zero form used another bank");
  AST_EXCHANGE: assert property (@(posedge clk) disable iff (rst) // RULE3
    exec && instr.op == OP_XCH && instr.addr[7] == 1'b0 |=> acc == $past(m) && flags == $past(flags) && busy)
    else $error("exchange result or timing wrong");
  AST_ADD_CARRY: assert property (@(posedge clk) disable iff (rst) // RULE5
    exec && instr.op inside {OP_ADD_A_M, OP_ADDC_A_M}
    |=> {flags[FLAG_C], acc} == {1'b0, $past(acc)} + {1'b0, $past(m)}
        + {8'h00, instr.op == OP_ADDC_A_M && $past(flags[FLAG_C])})
    else $error("add carry or sum wrong");
  AST_SUB_BORROW: assert property (@(posedge clk) disable iff (rst) // RULE6
    exec && instr.op inside {OP_SUB_A_M, OP_SUB_A_I}
    |=> flags[FLAG_C] == ($past(acc) >= (instr.op == OP_SUB_A_I ? instr.imm : $past(m))))
    else $error("subtract carry not inverted borrow");
  AST_MUL: assert property (@(posedge clk) disable iff (rst) // RULE7
    exec && instr.op == OP_MUL |=> {sysr[SYS_MULHI], acc} == {8'h00, $past(acc)} * {8'h00, $past(m)} && busy)
    else $error("multiply product or timing wrong");
  AST_LOGIC_FLAGS: assert property (@(posedge clk) disable iff (rst) // RULE8
    exec && instr.op inside {OP_AND_A_I, OP_OR_A_I, OP_XOR_A_I}
    |=> flags[1:0] == $past(flags[1:0]))
    else $error("logic op changed carry flags");
  AST_BIT_SKIP: assert property (@(posedge clk) disable iff (rst) // RULE14
    exec && instr.op == OP_BIT_SKIP_SET |-> skip == m[instr.bit_sel] && cycles == 2'h1 + {1'b0, skip})
    else $error("bit test skip wrong");
  AST_JUMP: assert property (@(posedge clk) disable iff (rst) // RULE15
    exec && instr.op == OP_JMP |=> pc == {$past(sysr[SYS_PAGE][1:0]), instr.addr[5:0], instr.imm} ##0 busy)
    else $error("jump target or timing wrong");
  AST_CALL_PUSH: assert property (@(posedge clk) disable iff (rst) // RULE16
    exec && instr.op == OP_CALL |=> stack[$past(sp)] == $past(pc) + 16'h0001 && sp == $past(sp) + 3'h1)
    else $error("call did not push return address");
  AST_RAM_EXTRA: assert property (@(posedge clk) disable iff (rst) // RULE19
    exec && instr.op == OP_SWAP_M |-> cycles == (instr.addr[7] ? 2'h1 : 2'h2))
    else $error("RAM operand cycle count wrong");
endmodule

// *** inc/mcuie_pkg.sv ***
// Shared constants, register map, opcode set and carrier types of the instruction execute core
package mcuie_pkg;
  // Wishbone register offsets (byte addresses)
  localparam logic [7:0] ADR_INSTR = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_ACC = 8'h08;
  localparam logic [7:0] ADR_PC = 8'h0C;
  localparam logic [7:0] ADR_MEM_ADDR = 8'h10;
  localparam logic [7:0] ADR_MEM_DATA = 8'h14;
  localparam logic [7:0] ADR_CTRL = 8'h18;
  // Status and control field positions
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_SKIP_BIT = 1;
  localparam int ST_CYC_LSB = 2;
  localparam int ST_GIE_BIT = 4;
  localparam int CTRL_GIE_BIT = 0;
  // System register window and indexes
  localparam logic [7:0] SYS_LAST = 8'h87;
  localparam logic [2:0] SYS_MULHI = 3'h2;
  localparam logic [2:0] SYS_PTR_LO = 3'h3;
  localparam logic [2:0] SYS_PTR_HI = 3'h4;
  localparam logic [2:0] SYS_PAGE = 3'h5;
  localparam logic [2:0] SYS_FLAGS = 3'h6;
  localparam logic [2:0] SYS_BANK = 3'h7;
  // Program flag register bits
  localparam int FLAG_C = 0;
  localparam int FLAG_DIGIT = 1;
  localparam int FLAG_Z = 2;
  // Storage sizes
  localparam int SYS_REGS = 8;
  localparam int RAM_SIZE = 256;
  localparam int STACK_DEPTH = 8;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_PC = 16'h0000;
  // Cycle counts
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;

  typedef enum logic [5:0] {
    OP_NOP = 6'b000000, OP_MOV_A_M = 6'b000001, OP_MOV_M_A = 6'b000010, OP_BZ_MOV_A_M = 6'b000011,
    OP_BZ_MOV_M_A = 6'b000100, OP_MOV_A_I = 6'b000101, OP_BZ_MOV_M_I = 6'b000110, OP_XCH = 6'b000111,
    OP_BZ_XCH = 6'b001000, OP_ROM_READ = 6'b001001, OP_ADDC_A_M = 6'b001010, OP_ADDC_M_A = 6'b001011,
    OP_ADD_A_M = 6'b001100, OP_ADD_M_A = 6'b001101, OP_BZ_ADD_M_A = 6'b001110, OP_ADD_A_I = 6'b001111,
    OP_SUBB_A_M = 6'b010000, OP_SUBB_M_A = 6'b010001, OP_SUB_A_M = 6'b010010, OP_SUB_M_A = 6'b010011,
    OP_SUB_A_I = 6'b010100, OP_MUL = 6'b010101, OP_AND_A_M = 6'b010110, OP_AND_M_A = 6'b010111,
    OP_AND_A_I = 6'b011000, OP_OR_A_M = 6'b011001, OP_OR_M_A = 6'b011010, OP_OR_A_I = 6'b011011,
    OP_XOR_A_M = 6'b011100, OP_XOR_M_A = 6'b011101, OP_XOR_A_I = 6'b011110, OP_SWAP_A = 6'b011111,
    OP_SWAP_M = 6'b100000, OP_RRC_A = 6'b100001, OP_RRC_M = 6'b100010, OP_RLC_A = 6'b100011,
    OP_RLC_M = 6'b100100, OP_CLR = 6'b100101, OP_BCLR = 6'b100110, OP_BSET = 6'b100111,
    OP_BZ_BCLR = 6'b101000, OP_BZ_BSET = 6'b101001, OP_CMP_SKIP_I = 6'b101010, OP_CMP_SKIP_M = 6'b101011,
    OP_INC_SKIP_A = 6'b101100, OP_INC_SKIP_M = 6'b101101, OP_DEC_SKIP_A = 6'b101110, OP_DEC_SKIP_M = 6'b101111,
    OP_BIT_SKIP_CLR = 6'b110000, OP_BIT_SKIP_SET = 6'b110001, OP_BZ_BIT_SKIP_CLR = 6'b110010,
    OP_BZ_BIT_SKIP_SET = 6'b110011, OP_JMP = 6'b110100, OP_CALL = 6'b110101, OP_RET = 6'b110110,
    OP_RETI = 6'b110111, OP_PUSH = 6'b111000, OP_POP = 6'b111001
  } mcuie_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_ROM = 2'b10,
    ST_WAIT = 2'b11
  } mcuie_state_t;

  // Instruction word as written to the instruction register, bits 24..0
  typedef struct packed {
    mcuie_op_t op;
    logic [2:0] bit_sel;
    logic [7:0] addr;
    logic [7:0] imm;
  } mcuie_instr_t;

  // Wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } mcuie_wb_req_t;
endpackage

// *** test/mcuie_core_bench.sv ***
// Self-checking bench of the instruction execute core
module mcuie_core_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import mcuie_pkg::*;
  typedef struct packed {
    logic [7:0] ad, im, a, m, f, ea, em, ef;
  } mcuie_byt_t;
  typedef struct packed {
    mcuie_op_t op;
    logic [2:0] b;
    mcuie_byt_t v;
    logic [2:0] cs;
  } mcuie_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  mcuie_wb_req_t req = '0;
  logic [31:0] wb_dat_o, q;
  logic wb_ack_o, busy, gie, rom_rd;
  logic [15:0] rom_addr, rom_data;
  int err_total = 0, n_compared = 0;
  int n_rom = 0;
  // Address, immediate, acc, mem, flags in; acc, mem, flags out; {cycles, skip}
  mcuie_row_t rows [20] = '{
    '{OP_ADD_M_A, 3'h0, 64'h1000F02000F01001, 3'h4}, '{OP_ADDC_A_M, 3'h0, 64'h80000F0001100002, 3'h2},
    '{OP_SUBB_A_M, 3'h0, 64'h1000050500FF0500, 3'h2}, '{OP_SUB_A_I, 3'h0, 64'h0003030000000007, 3'h2},
    '{OP_MUL, 3'h0, 64'h8200102003000207, 3'h4}, '{OP_AND_M_A, 3'h0, 64'h10000FF0030F0007, 3'h4},
    '{OP_XOR_A_I, 3'h0, 64'h10FF0F0007F00003, 3'h2}, '{OP_SWAP_M, 3'h0, 64'h1000003C0500C305, 3'h4},
    '{OP_RLC_M, 3'h0, 64'h1000008100000201, 3'h4}, '{OP_RRC_A, 3'h0, 64'h8000000101800101, 3'h2},
    '{OP_BZ_BCLR, 3'h7, 64'h100000FF00007F00, 3'h4}, '{OP_BSET, 3'h3, 64'h8100000000000800, 3'h2},
    '{OP_XCH, 3'h0, 64'h1000112207221107, 3'h4}, '{OP_CMP_SKIP_I, 3'h0, 64'h1042420000420005, 3'h5},
    '{OP_INC_SKIP_M, 3'h0, 64'h100000FF02000002, 3'h7}, '{OP_DEC_SKIP_A, 3'h0, 64'h1000000200010200, 3'h2},
    '{OP_BIT_SKIP_CLR, 3'h0, 64'h100000FE0000FE00, 3'h5}, '{OP_BIT_SKIP_SET, 3'h0, 64'h100000FE0000FE00, 3'h2},
    '{OP_BZ_MOV_M_I, 3'h0, 64'h835A000000005A00, 3'h2}, '{OP_ROM_READ, 3'h0, 64'h8300003400CB3400, 3'h4}
  };
  always #4 clk = ~clk;
  // Table word carries its own address so the two halves are told apart
  assign rom_data = {rom_addr[7:0], ~rom_addr[7:0]};
  // Counts table-read strobes
  always @(posedge clk) begin
    if (rom_rd === 1'b1) n_rom++;
  end
  mcuie_core i_mcuie_core (.clk(clk), .rst(rst), .ce(ce), .wb_req(req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .rom_addr(rom_addr), .rom_rd(rom_rd), .rom_data(rom_data), .busy(busy), .gie(gie));
  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic hang();
    chk(32'h0, 32'h1);
    end_of_test();
  endtask
  // Classic cycle: hold the request until the edge that samples ack high, take data and release there
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    @(posedge clk);
    req <= '{1'b1, 1'b1, w, ad, 4'hF, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) hang();
    q = wb_dat_o;
    req <= '0;
  endtask
  // Issue one instruction and poll until busy clears; q keeps the final status
  task automatic exec(input mcuie_op_t op, input logic [2:0] b, input logic [7:0] ad, input logic [7:0] im);
    int n;
    bus(1'b1, ADR_INSTR, {7'h00, op, b, ad, im});
    n = 0;
    do begin
      bus(1'b0, ADR_STATUS, 32'h0);
      n++;
    end while (q[ST_BUSY_BIT] !== 1'b0 && n < 20);
    if (q[ST_BUSY_BIT] !== 1'b0) hang();
  endtask
  task automatic setm(input logic [8:0] ad, input logic [7:0] d);
    bus(1'b1, ADR_MEM_ADDR, {23'h0, ad});
    bus(1'b1, ADR_MEM_DATA, {24'h0, d});
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, ADR_PC, 32'h0);
    chk(q, 32'h0);
    foreach (rows[i]) begin
      bus(1'b1, ADR_ACC, {24'h0, rows[i].v.a});
      setm(9'h086, rows[i].v.f);
      setm({1'b0, rows[i].v.ad}, rows[i].v.m);
      exec(rows[i].op, rows[i].b, rows[i].v.ad, rows[i].v.im);
      chk({29'h0, q[3:1]}, {29'h0, rows[i].cs});
      bus(1'b0, ADR_ACC, 32'h0);
      chk(q, {24'h0, rows[i].v.ea});
      bus(1'b0, ADR_MEM_DATA, 32'h0);
      chk(q, {24'h0, rows[i].v.em});
      bus(1'b1, ADR_MEM_ADDR, 32'h86);
      bus(1'b0, ADR_MEM_DATA, 32'h0);
      chk(q, {24'h0, rows[i].v.ef});
    end
    // Bank one selected, bank-zero read must still see bank zero
    setm(9'h087, 8'h01);
    exec(OP_BZ_MOV_A_M, 3'h0, 8'h10, 8'h00);
    bus(1'b0, ADR_ACC, 32'h0);
    chk(q, 32'hFE);
    setm(9'h085, 8'h01);
    exec(OP_JMP, 3'h0, 8'h12, 8'h34);
    bus(1'b0, ADR_PC, 32'h0);
    chk(q, 32'h5234);
    exec(OP_CALL, 3'h0, 8'h00, 8'h10);
    exec(OP_RETI, 3'h0, 8'h00, 8'h00);
    bus(1'b0, ADR_PC, 32'h0);
    chk(q, 32'h5235);
    chk({31'h0, gie}, 32'h1);
    chk({31'h0, busy}, 32'h0);
    chk({16'h0, rom_addr}, 32'h34);
    chk(n_rom, 32'h1);
    // Shadow copy survives an accumulator overwrite
    bus(1'b1, ADR_ACC, 32'h3C);
    exec(OP_PUSH, 3'h0, 8'h00, 8'h00);
    exec(OP_MOV_A_I, 3'h0, 8'h00, 8'hC3);
    exec(OP_POP, 3'h0, 8'h00, 8'h00);
    bus(1'b0, ADR_ACC, 32'h0);
    chk(q, 32'h3C);
    end_of_test();
  end
endmodule
